/* File: pwrc_defines.svh */
`ifndef PWRC_DEFINES_SVH
`define PWRC_DEFINES_SVH

// Register indices; byte address is four times the index.
`define PWRC_IDX_RST_SRC 8'hE5
`define PWRC_IDX_MISC 8'hE6
`define PWRC_IDX_WAKE_KEY 8'hE7
`define PWRC_IDX_PME_GLOBAL 8'hF2
`define PWRC_IDX_PME_STS_LO 8'hF3
`define PWRC_IDX_PME_STS_HI 8'hF4
`define PWRC_IDX_POLICY 8'hE4
`define PWRC_IDX_PME_EN_LO 8'hF6
`define PWRC_IDX_PME_EN_HI 8'hF7

// Reset values.
`define PWRC_RST_SRC_RESET 8'h00
`define PWRC_MISC_RESET 8'h1C
`define PWRC_WAKE_KEY_RESET 8'h00
`define PWRC_PME_GLOBAL_RESET 8'h3E
`define PWRC_POLICY_RESET 2'h0

// Field positions.
`define PWRC_RST_GPIO_HI 7
`define PWRC_RST_GPIO_LO 3
`define PWRC_RST_GPIO_PINS_25_TO_27 2
`define PWRC_MISC_MOUSE_C 7
`define PWRC_MISC_CASE_CLR 5
`define PWRC_MISC_LAST_STATE 4
`define PWRC_MISC_DLY_HI 3
`define PWRC_MISC_DLY_LO 1
`define PWRC_MISC_PG_TRIG 0
`define PWRC_WK_THIRD_SET 7
`define PWRC_WK_SECOND_SET 6
`define PWRC_WK_OS_KEY 5
`define PWRC_WK_RESTORE_PULSE 4
`define PWRC_WK_WDT_SRC 3
`define PWRC_WK_HWM_SRC 0
`define PWRC_PME_GLOBAL_EN 0

// Power-good delays, lower bound of each range, in milliseconds.
`define PWRC_PG_DLY0_MS 300
`define PWRC_PG_DLY1_MS 330
`define PWRC_PG_DLY2_MS 390
`define PWRC_PG_DLY3_MS 520
`define PWRC_PG_DLY4_MS 200
`define PWRC_PG_DLY5_MS 230
`define PWRC_PG_DLY6_MS 290
`define PWRC_PG_DLY7_MS 420
`define PWRC_RESTORE_DLY_MS 500
`define PWRC_CLK_MHZ 125
`define PWRC_MS_NS 1000000
`define PWRC_CLK_NS 8

`endif

/* File: pwrc_host_model.sv */
`timescale 1ns/10ps
module pwrc_host_model (
  input wire logic aclk,
  input wire logic [1:0] cmd,
  input wire logic power_switch_output_n,
  output logic main_supply_good
);
  // Command 1 cuts the supply and 2 turns it on; a switch held low for three
  // cycles also turns it on, so a too-short pulse from the block is not honoured.
  logic [1:0] low_cnt = 2'h0;
  initial main_supply_good = 1'b0;
  always @(posedge aclk) begin
    low_cnt <= power_switch_output_n ? 2'h0 : (low_cnt == 2'h3 ? low_cnt : low_cnt + 2'h1);
    if (cmd == 2'h1) main_supply_good <= 1'b0;
    else if (cmd == 2'h2 || low_cnt == 2'h3) main_supply_good <= 1'b1;
  end
endmodule // pwrc_host_model

/* File: pwrc_pkg.sv */
package pwrc_pkg;
  typedef enum logic [3:0] {
    PWRC_PG_OFF = 4'h1,
    PWRC_PG_WAIT = 4'h2,
    PWRC_PG_ON = 4'h4,
    PWRC_PG_DROP = 4'h8
  } pwrc_pg_state_t;
  typedef enum logic [1:0] {
    PWRC_POL_OFF = 2'h0,
    PWRC_POL_ON = 2'h1,
    PWRC_POL_PREV = 2'h2,
    PWRC_POL_LAST = 2'h3
  } pwrc_policy_t;
endpackage

/* File: pwrc_top.sv */
`timescale 1ns/10ps
`include "pwrc_defines.svh"
module pwrc_top
  import pwrc_pkg::*;
#(
  parameter int MS_CYCLES = (`PWRC_MS_NS / `PWRC_CLK_NS),
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lpc_reset_n,
  input wire logic resume_well_reset_n,
  input wire logic main_supply_good,
  input wire logic power_loss_return,
  input wire logic system_was_on,
  input wire logic [6:0] pme_event_low,
  input wire logic [5:0] pme_event_high,
  input wire logic mouse_wake_key_select_a,
  input wire logic mouse_wake_key_select_b,
  input wire logic kb_wake_enable,
  input wire logic kb_first_set_match,
  input wire logic kb_second_set_match,
  input wire logic kb_third_set_match,
  input wire logic kb_os_key,
  output logic [4:0] gpio_group_reset,
  output logic gpio_pins_25_to_27_reset,
  output logic watchdog_reset,
  output logic hw_monitor_reset,
  output logic caseopen_clear,
  output logic power_good_output,
  output logic power_switch_output_n,
  output logic [2:0] mouse_wake_mode,
  output logic kb_wake_event,
  output logic pme_n
);

  logic [7:0] reset_source;
  logic mouse_select_c;
  logic last_state_flag;
  logic [2:0] power_good_delay_sel;
  logic third_key_set_enable;
  logic second_key_set_enable;
  logic os_key_wake_enable;
  logic power_restore_pulse_enable;
  logic watchdog_src_sel;
  logic hw_monitor_src_sel;
  logic global_wake_event_enable;
  logic [1:0] power_loss_policy;
  logic [6:0] pme_status_lo;
  logic [5:0] pme_status_hi;
  logic [6:0] pme_enable_lo;
  logic [5:0] pme_enable_hi;
  logic power_good_retrigger;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Write channel: address and data are taken in the same cycle.
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire wr_fire = s_axi_awready;
  wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  wire [7:0] wr_idx = wr_addr[9:2];
  wire wr_top_zero = (wr_addr[ADDR_W-1:10] == '0);
  wire wr_lane = wr_fire && wr_top_zero && s_axi_wstrb[0];
  wire wr_rst_src = wr_lane && (wr_idx == `PWRC_IDX_RST_SRC);
  wire wr_misc = wr_lane && (wr_idx == `PWRC_IDX_MISC);
  wire wr_wake = wr_lane && (wr_idx == `PWRC_IDX_WAKE_KEY);
  wire wr_global = wr_lane && (wr_idx == `PWRC_IDX_PME_GLOBAL);
  wire wr_sts_lo = wr_lane && (wr_idx == `PWRC_IDX_PME_STS_LO);
  wire wr_sts_hi = wr_lane && (wr_idx == `PWRC_IDX_PME_STS_HI);
  wire wr_policy = wr_lane && (wr_idx == `PWRC_IDX_POLICY);
  wire wr_en_lo = wr_lane && (wr_idx == `PWRC_IDX_PME_EN_LO);
  wire wr_en_hi = wr_lane && (wr_idx == `PWRC_IDX_PME_EN_HI);
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire rd_top_zero = (s_axi_araddr[ADDR_W-1:10] == '0);
  wire wr_known = wr_top_zero && (wr_rst_src || wr_misc || wr_wake || wr_global ||
    wr_sts_lo || wr_sts_hi || wr_policy || wr_en_lo || wr_en_hi ||
    !s_axi_wstrb[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      wr_addr <= '0;
      wr_byte <= 8'h00;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        wr_addr <= s_axi_awaddr;
        wr_byte <= s_axi_wdata[7:0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; unmapped indices answer zero with a slave error.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = 2'h0;
    if (!rd_top_zero) begin
      next_rresp = 2'h2;
    end else begin
      case (rd_idx)
        `PWRC_IDX_RST_SRC: next_rdata[7:0] = {reset_source[7:2], 2'b00};
        `PWRC_IDX_MISC: next_rdata[7:0] = {mouse_select_c, 2'b00, last_state_flag,
          power_good_delay_sel, 1'b0};
        `PWRC_IDX_WAKE_KEY: next_rdata[7:0] = {third_key_set_enable,
          second_key_set_enable, os_key_wake_enable, power_restore_pulse_enable,
          watchdog_src_sel, 2'b00, hw_monitor_src_sel};
        `PWRC_IDX_PME_GLOBAL: next_rdata[7:0] = {7'(`PWRC_PME_GLOBAL_RESET >> 1),
          global_wake_event_enable};
        `PWRC_IDX_PME_STS_LO: next_rdata[7:0] = {1'b0, pme_status_lo};
        `PWRC_IDX_PME_STS_HI: next_rdata[7:0] = {2'b00, pme_status_hi};
        `PWRC_IDX_POLICY: next_rdata[7:0] = {1'b0, power_loss_policy, 5'h00};
        `PWRC_IDX_PME_EN_LO: next_rdata[7:0] = {1'b0, pme_enable_lo};
        `PWRC_IDX_PME_EN_HI: next_rdata[7:0] = {2'b00, pme_enable_hi};
        default: next_rresp = 2'h2;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_source <= `PWRC_RST_SRC_RESET;
      mouse_select_c <= 1'((`PWRC_MISC_RESET >> `PWRC_MISC_MOUSE_C));
      last_state_flag <= 1'((`PWRC_MISC_RESET >> `PWRC_MISC_LAST_STATE));
      power_good_delay_sel <= 3'((`PWRC_MISC_RESET >> `PWRC_MISC_DLY_LO));
      third_key_set_enable <= 1'b0;
      second_key_set_enable <= 1'b0;
      os_key_wake_enable <= 1'b0;
      power_restore_pulse_enable <= 1'b0;
      watchdog_src_sel <= 1'b0;
      hw_monitor_src_sel <= 1'b0;
      global_wake_event_enable <= 1'b0;
      power_loss_policy <= `PWRC_POLICY_RESET;
      pme_enable_lo <= 7'h00;
      pme_enable_hi <= 6'h00;
    end else begin
      if (wr_rst_src) begin
        reset_source <= {wr_byte[7:2], 2'b00};
      end
      if (wr_misc) begin
        mouse_select_c <= wr_byte[`PWRC_MISC_MOUSE_C];
        last_state_flag <= wr_byte[`PWRC_MISC_LAST_STATE];
        power_good_delay_sel <= wr_byte[`PWRC_MISC_DLY_HI:`PWRC_MISC_DLY_LO];
      end
      if (wr_wake) begin
        third_key_set_enable <= wr_byte[`PWRC_WK_THIRD_SET];
        second_key_set_enable <= wr_byte[`PWRC_WK_SECOND_SET];
        os_key_wake_enable <= wr_byte[`PWRC_WK_OS_KEY];
        power_restore_pulse_enable <= wr_byte[`PWRC_WK_RESTORE_PULSE];
        watchdog_src_sel <= wr_byte[`PWRC_WK_WDT_SRC];
        hw_monitor_src_sel <= wr_byte[`PWRC_WK_HWM_SRC];
      end
      if (wr_global) begin
        global_wake_event_enable <= wr_byte[`PWRC_PME_GLOBAL_EN];
      end
      if (wr_policy) begin
        power_loss_policy <= wr_byte[6:5];
      end
      if (wr_en_lo) begin
        pme_enable_lo <= wr_byte[6:0];
      end
      if (wr_en_hi) begin
        pme_enable_hi <= wr_byte[5:0];
      end
    end
  end

  // Status bits: a new event in the clearing cycle wins over the clear.
  wire [6:0] clr_lo = wr_sts_lo ? wr_byte[6:0] : 7'h00;
  wire [5:0] clr_hi = wr_sts_hi ? wr_byte[5:0] : 6'h00;
  wire pme_pending = global_wake_event_enable &&
    (|(pme_status_lo & pme_enable_lo) || |(pme_status_hi & pme_enable_hi));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pme_status_lo <= 7'h00;
      pme_status_hi <= 6'h00;
      pme_n <= 1'b1;
    end else begin
      pme_status_lo <= (pme_status_lo & ~clr_lo) | pme_event_low;
      pme_status_hi <= (pme_status_hi & ~clr_hi) | pme_event_high;
      pme_n <= !pme_pending;
    end
  end

  // Reset routing for the neighbouring blocks.
  wire lpc_rst = !lpc_reset_n;
  wire [4:0] next_gpio_reset = {5{lpc_rst}} &
    ~reset_source[`PWRC_RST_GPIO_HI:`PWRC_RST_GPIO_LO];
  wire next_gp_pins_reset = reset_source[`PWRC_RST_GPIO_PINS_25_TO_27] ?
    !resume_well_reset_n : lpc_rst;
  wire next_wdt_reset = watchdog_src_sel ? !power_good_output : lpc_rst;
  wire next_hwm_reset = hw_monitor_src_sel ? lpc_rst : !power_good_output;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_group_reset <= 5'h1F;
      gpio_pins_25_to_27_reset <= 1'b1;
      watchdog_reset <= 1'b1;
      hw_monitor_reset <= 1'b1;
      caseopen_clear <= 1'b0;
      mouse_wake_mode <= 3'h0;
      power_good_retrigger <= 1'b0;
    end else begin
      gpio_group_reset <= next_gpio_reset;
      gpio_pins_25_to_27_reset <= next_gp_pins_reset;
      watchdog_reset <= next_wdt_reset;
      hw_monitor_reset <= next_hwm_reset;
      caseopen_clear <= wr_misc && wr_byte[`PWRC_MISC_CASE_CLR];
      power_good_retrigger <= wr_misc && wr_byte[`PWRC_MISC_PG_TRIG];
      mouse_wake_mode <= {mouse_select_c, mouse_wake_key_select_a,
        mouse_wake_key_select_b};
    end
  end

  // Millisecond tick shared by both long delays; shorten MS_CYCLES in simulation.
  logic [31:0] tick_cnt;
  wire ms_tick = (tick_cnt == 32'(MS_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= ms_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // Power-good sequencing; the shortest time of each range is used.
  logic [9:0] pg_delay_ms;
  always_comb begin
    case (power_good_delay_sel)
      3'h0: pg_delay_ms = 10'(`PWRC_PG_DLY0_MS);
      3'h1: pg_delay_ms = 10'(`PWRC_PG_DLY1_MS);
      3'h2: pg_delay_ms = 10'(`PWRC_PG_DLY2_MS);
      3'h3: pg_delay_ms = 10'(`PWRC_PG_DLY3_MS);
      3'h4: pg_delay_ms = 10'(`PWRC_PG_DLY4_MS);
      3'h5: pg_delay_ms = 10'(`PWRC_PG_DLY5_MS);
      3'h6: pg_delay_ms = 10'(`PWRC_PG_DLY6_MS);
      default: pg_delay_ms = 10'(`PWRC_PG_DLY7_MS);
    endcase
  end

  pwrc_pg_state_t pg_state;
  pwrc_pg_state_t next_pg_state;
  logic [9:0] pg_ms;
  wire pg_done = ms_tick && (pg_ms + 10'h001 >= pg_delay_ms);

  always_comb begin
    next_pg_state = pg_state;
    case (pg_state)
      PWRC_PG_OFF: if (main_supply_good) next_pg_state = PWRC_PG_WAIT;
      PWRC_PG_WAIT: begin
        if (!main_supply_good) begin
          next_pg_state = PWRC_PG_OFF;
        end else if (pg_done) begin
          next_pg_state = PWRC_PG_ON;
        end
      end
      PWRC_PG_ON: begin
        if (!main_supply_good) begin
          next_pg_state = PWRC_PG_OFF;
        end else if (power_good_retrigger) begin
          next_pg_state = PWRC_PG_DROP;
        end
      end
      PWRC_PG_DROP: next_pg_state = main_supply_good ? PWRC_PG_WAIT : PWRC_PG_OFF;
      default: next_pg_state = PWRC_PG_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pg_state <= PWRC_PG_OFF;
      pg_ms <= 10'h000;
      power_good_output <= 1'b0;
    end else begin
      pg_state <= next_pg_state;
      if (next_pg_state != PWRC_PG_WAIT || pg_state != PWRC_PG_WAIT) begin
        pg_ms <= 10'h000;
      end else if (ms_tick) begin
        pg_ms <= pg_ms + 10'h001;
      end
      power_good_output <= (next_pg_state == PWRC_PG_ON);
    end
  end

  // Keyboard wake: with kb_wake_enable set, the first set always matches, the others only when enabled.
  wire kb_wake_hit = kb_wake_enable && (kb_first_set_match ||
    (second_key_set_enable && kb_second_set_match) ||
    (third_key_set_enable && kb_third_set_match) ||
    (os_key_wake_enable && kb_os_key));

  // Decide whether the system is meant to come back on after power loss.
  logic restore_on;
  always_comb begin
    case (pwrc_policy_t'(power_loss_policy))
      PWRC_POL_OFF: restore_on = 1'b0;
      PWRC_POL_ON: restore_on = 1'b1;
      PWRC_POL_PREV: restore_on = system_was_on;
      PWRC_POL_LAST: restore_on = !last_state_flag;
      default: restore_on = 1'b0;
    endcase
  end

  // The switch level is held until main supply rises, so a slow supply is not cut short.
  logic restore_wait;
  logic [9:0] restore_ms;
  logic switch_hold;
  wire restore_go = power_loss_return && restore_on && power_restore_pulse_enable;
  wire restore_done = restore_wait && ms_tick &&
    (restore_ms + 10'h001 >= 10'(`PWRC_RESTORE_DLY_MS));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restore_wait <= 1'b0;
      restore_ms <= 10'h000;
      switch_hold <= 1'b0;
      power_switch_output_n <= 1'b1;
      kb_wake_event <= 1'b0;
    end else begin
      kb_wake_event <= kb_wake_hit;
      if (restore_go) begin
        restore_wait <= 1'b1;
        restore_ms <= 10'h000;
      end else if (restore_done) begin
        restore_wait <= 1'b0;
      end else if (restore_wait && ms_tick) begin
        restore_ms <= restore_ms + 10'h001;
      end
      if (main_supply_good) begin
        switch_hold <= 1'b0;
      end else if (restore_done || kb_wake_hit) begin
        switch_hold <= 1'b1;
      end
      power_switch_output_n <= !(switch_hold && !main_supply_good);
    end
  end

endmodule // pwrc_top

/* File: pwrc_top_props.sv */
`timescale 1ns/10ps
module pwrc_top_props
  import pwrc_pkg::*;
#(
  parameter int MS_CYCLES = 4,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lpc_reset_n,
  input wire logic resume_well_reset_n,
  input wire logic main_supply_good,
  input wire logic mouse_wake_key_select_a,
  input wire logic mouse_wake_key_select_b,
  input wire logic kb_wake_enable,
  input wire logic kb_first_set_match,
  input wire logic kb_second_set_match,
  input wire logic kb_third_set_match,
  input wire logic kb_os_key,
  input wire logic [4:0] gpio_group_reset,
  input wire logic gpio_pins_25_to_27_reset,
  input wire logic watchdog_reset,
  input wire logic hw_monitor_reset,
  input wire logic caseopen_clear,
  input wire logic power_good_output,
  input wire logic power_switch_output_n,
  input wire logic [2:0] mouse_wake_mode,
  input wire logic kb_wake_event
);
  // Attempts started on the release edge would still see reset values one edge later.
  logic live;
  always_ff @(posedge aclk) live <= aresetn;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !live);
  a_gpio_lpc_free: assert property (lpc_reset_n |=> gpio_group_reset == 5'h00)
    else $error("GPIO group held in reset without LPC reset");
  a_pins_free: assert property (lpc_reset_n && resume_well_reset_n |=>
    !gpio_pins_25_to_27_reset)
    else $error("Pins 25 to 27 held in reset with no reset source");
  a_wdt_free: assert property (lpc_reset_n && power_good_output |=> !watchdog_reset)
    else $error("Watchdog held in reset with no reset source");
  a_hwm_free: assert property (lpc_reset_n && power_good_output |=> !hw_monitor_reset)
    else $error("Monitor held in reset with no reset source");
  a_clear_one_pulse: assert property (caseopen_clear |=> !caseopen_clear)
    else $error("Case-open clear longer than one cycle");
  a_pg_low_hold: assert property ($fell(power_good_output) |=> !power_good_output [*8])
    else $error("Power-good came back too soon");
  a_pg_no_supply: assert property (!main_supply_good [*3] |-> !power_good_output)
    else $error("Power-good high without main supply");
  a_mouse_mode: assert property ($past(aresetn) |->
    mouse_wake_mode[1:0] == $past({mouse_wake_key_select_a, mouse_wake_key_select_b}))
    else $error("Mouse wake mode does not follow its selects");
  a_kb_cause: assert property (kb_wake_event |->
    $past(kb_wake_enable && (kb_first_set_match || kb_second_set_match
    || kb_third_set_match || kb_os_key)))
    else $error("Keyboard wake event without a match");
  c_pg_rise: cover property ($rose(power_good_output));
  c_kb_wake: cover property (kb_wake_event);
  c_switch: cover property ($fell(power_switch_output_n));
endmodule // pwrc_top_props

bind pwrc_top pwrc_top_props #(.MS_CYCLES(MS_CYCLES), .ADDR_W(ADDR_W)) u_props (.*);

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pwrc_pkg::*;
  localparam int M = 4;
  localparam int DLY [8] = '{300, 330, 390, 520, 200, 230, 290, 420};
  localparam logic [7:0] IDX [6] = '{8'hE5, 8'hE6, 8'hE7, 8'hF2, 8'hF3, 8'hF4};
  localparam logic [7:0] RST [6] = '{8'h00, 8'h1C, 8'h00, 8'h3E, 8'h00, 8'h00};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, mouse_wake_mode;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b, cmd = 2'h0;
  logic lpc_reset_n = 1'b1, resume_well_reset_n = 1'b1, power_loss_return = 1'b0;
  logic system_was_on = 1'b1, mouse_wake_key_select_a = 1'b0, mouse_wake_key_select_b = 1'b0;
  logic kb_wake_enable = 1'b0, kb_first_set_match = 1'b0, kb_second_set_match = 1'b0;
  logic kb_third_set_match = 1'b0, kb_os_key = 1'b0;
  logic [6:0] pme_event_low = 7'h00;
  logic [5:0] pme_event_high = 6'h00;
  logic main_supply_good, gpio_pins_25_to_27_reset, watchdog_reset, hw_monitor_reset;
  logic caseopen_clear, power_good_output, power_switch_output_n, kb_wake_event, pme_n;
  logic [4:0] gpio_group_reset;
  logic [31:0] rd_w;
  int errors = 0, n_tests = 0, kb_cnt = 0, co_cnt = 0, n;

  pwrc_top #(.MS_CYCLES(M)) uut (.*);
  pwrc_host_model u_host (.aclk(aclk), .cmd(cmd), .power_switch_output_n(power_switch_output_n),
    .main_supply_good(main_supply_good));

  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (kb_wake_event === 1'b1) kb_cnt <= kb_cnt + 1;
    if (caseopen_clear === 1'b1) co_cnt <= co_cnt + 1;
  end

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wr_b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_w = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] idx, input logic [31:0] exp, input string m);
    rd(idx);
    chk(rd_w, exp, m);
  endtask
  task supply(input logic [1:0] c);
    @(posedge aclk);
    cmd <= c;
    @(posedge aclk);
    cmd <= 2'h0;
  endtask
  task wait_pg(output int k);
    k = 0;
    while (power_good_output !== 1'b1) begin
      @(posedge aclk);
      k++;
    end
  endtask
  // Each key attempt starts from a cut supply, since a hit turns the supply back on.
  task kb(input logic [2:0] v, input int inc);
    int c0;
    supply(2'h1);
    tick(3);
    c0 = kb_cnt;
    @(posedge aclk);
    {kb_third_set_match, kb_second_set_match, kb_os_key} <= v;
    @(posedge aclk);
    {kb_third_set_match, kb_second_set_match, kb_os_key} <= 3'h0;
    tick(3);
    chk(kb_cnt - c0, inc, "keyboard wake count");
  endtask
  task pme_one(input logic hi, input int i, input logic exp_n);
    logic [7:0] idx;
    idx = hi ? 8'hF4 : 8'hF3;
    @(posedge aclk);
    if (hi) pme_event_high <= 6'h01 << i;
    else pme_event_low <= 7'h01 << i;
    @(posedge aclk);
    pme_event_high <= 6'h00;
    pme_event_low <= 7'h00;
    tick(3);
    chk(pme_n, exp_n, "wake line with status set");
    rchk(idx, 32'h1 << i, "wake status set");
    wr(idx, 8'h01 << i);
    rchk(idx, 32'h0, "wake status cleared");
    chk(pme_n, 1'b1, "wake line released");
  endtask

  initial begin
    repeat (80000) @(posedge aclk);
    errors++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(IDX[i], RST[i], "reset value");
    rd(8'hE8);
    chk(rd_r, 2'h2, "unmapped access");
    wr(8'hE8, 8'h55);
    chk(wr_b, 2'h2, "unmapped write");
    for (int g = 0; g < 5; g++) begin
      wr(8'hE5, 8'h08 << g);
      lpc_reset_n <= 1'b0;
      tick(3);
      chk(gpio_group_reset, 5'h1F ^ (5'h01 << g), "group shield");
      chk(gpio_pins_25_to_27_reset, 1'b1, "pins follow LPC reset");
      lpc_reset_n <= 1'b1;
    end
    wr(8'hE5, 8'hFF);
    chk(wr_b, 2'h0, "mapped write");
    rchk(8'hE5, 32'hFC, "reset source readback");
    lpc_reset_n <= 1'b0;
    tick(3);
    chk({gpio_group_reset, gpio_pins_25_to_27_reset}, 6'h00, "all shielded");
    resume_well_reset_n <= 1'b0;
    tick(3);
    chk(gpio_pins_25_to_27_reset, 1'b1, "pins follow resume reset");
    lpc_reset_n <= 1'b1;
    resume_well_reset_n <= 1'b1;
    wr(8'hE5, 8'h00);
    mouse_wake_key_select_a <= 1'b1;
    wr(8'hE6, 8'hA1);
    tick(2);
    chk(co_cnt, 1, "case-open clear pulse");
    chk(mouse_wake_mode, 3'h6, "mouse wake mode");
    rchk(8'hE6, 32'h80, "self-clearing bits");
    for (int c = 0; c < 8; c++) begin
      wr(8'hE6, 8'(c << 1));
      rchk(8'hE6, c << 1, "delay code readback");
      supply(2'h1);
      tick(4);
      supply(2'h2);
      wait_pg(n);
      chk(n >= (DLY[c] - 1) * M && n <= (DLY[c] + 1) * M + 4, 1, "power-good delay");
    end
    wr(8'hE6, 8'h09);
    tick(2);
    chk(power_good_output, 1'b0, "retrigger drop");
    wait_pg(n);
    chk(n >= 198 * M && n <= 201 * M + 4, 1, "retrigger rise");
    supply(2'h1);
    tick(3);
    wr(8'hE7, 8'h08);
    tick(2);
    chk({watchdog_reset, hw_monitor_reset}, 2'h3, "power-good sources");
    wr(8'hE7, 8'h01);
    tick(2);
    chk({watchdog_reset, hw_monitor_reset}, 2'h0, "LPC sources");
    kb_wake_enable <= 1'b1;
    wr(8'hE7, 8'h40);
    kb(3'b010, 1);
    kb(3'b100, 0);
    kb(3'b001, 0);
    wr(8'hE7, 8'hA0);
    kb(3'b100, 1);
    kb(3'b010, 0);
    kb(3'b001, 1);
    kb_wake_enable <= 1'b0;
    kb(3'b001, 0);
    wr(8'hF2, 8'h01);
    rchk(8'hF2, 32'h3F, "global enable readback");
    wr(8'hF6, 8'h7E);
    wr(8'hF7, 8'h3F);
    for (int i = 0; i < 7; i++) pme_one(1'b0, i, i == 0);
    for (int i = 0; i < 6; i++) pme_one(1'b1, i, 1'b0);
    wr(8'hF2, 8'h00);
    pme_one(1'b0, 3, 1'b1);
    // Passes 4 and 5 repeat policies 10 and 11 with the system meant to stay off.
    for (int p = 0; p < 6; p++) begin
      wr(8'hE4, 8'((p > 3 ? p - 2 : p) << 5));
      wr(8'hE6, p > 4 ? 8'h18 : 8'h08);
      wr(8'hE7, 8'h10);
      system_was_on <= (p < 4);
      supply(2'h1);
      tick(3);
      power_loss_return <= 1'b1;
      @(posedge aclk);
      power_loss_return <= 1'b0;
      n = 0;
      while (power_switch_output_n !== 1'b0 && n < 600 * M) begin
        @(posedge aclk);
        n++;
      end
      chk(p == 0 || p > 3 ? n == 600 * M : n >= 498 * M && n <= 501 * M + 4, 1,
        "restore");
    end
    give_verdict;
  end
endmodule // tb_top
